/* hdl/bgw_ctrl.sv */
/*
 Block gap and wakeup control: AHB-Lite register slave, gap halt and
 continue sequencing, read-wait or clock-stop hold, card interrupt sampling
 and wakeup event generation, with a sticky interrupt status.
 Assumes the transfer engine, normal interrupt status and card pins sit
 outside; engine and status inputs are on hclk, card pins are asynchronous.

// Operation
// [RULE1] In 4-bit I/O multi-block transfers, sample card interrupts only at gaps if enabled.
// [RULE2] Software leaves gap interrupt off for cards unable to interrupt mid-transfer.
// [RULE3] On insertion, software sets gap interrupt and read wait per card capability.
// [RULE4] Read wait enabled holds read data on DAT[2]; otherwise the card clock stops.
// [RULE5] With read wait disabled, suspend and resume are not supported.
// [RULE6] Software never enables read wait for a card lacking it.
// [RULE7] In second-generation serial mode read wait is off; DAT[2] carries interrupts.
// [RULE8] Clearing stop and writing continue restarts a transfer halted at a gap.
// [RULE9] Continue writes are discarded while stop stays set.
// [RULE10] Continue clears itself when data-line or write-transfer activity rises.
// [RULE11] A set gap event is resumed by continue; no event means transfer done.
// [RULE12] Removal wakeup enable raises wakeup when removal status asserts.
// [RULE13] Insertion wakeup enable raises wakeup when insertion status asserts.
// [RULE14] Card interrupt wakeup enable raises wakeup when card interrupt status asserts.
// [RULE15] Software sets card interrupt wakeup only if the card supports wakeup.
// [RULE16] Software keeps bus power on when card interrupt wakeup is wanted.
// [RULE17] Stop request halts the multi-block transfer at the next gap until continued.
// [RULE18] Reserved control and wakeup bits read zero and ignore writes.
*/
`timescale 1ns/10ps
module bgw_ctrl (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	// Transfer engine status
	input  wire logic        xfer_multi,
	input  wire logic        xfer_read,
	input  wire logic        blk_gap_pulse,
	input  wire logic        gap_window,
	input  wire logic        dat_line_active,
	input  wire logic        write_xfer_active,
	// Transfer engine control
	output logic             gap_hold,
	output logic             card_clk_stop,
	output logic             sr_allowed,
	// Normal interrupt status levels
	input  wire logic        sts_card_insert,
	input  wire logic        sts_card_remove,
	input  wire logic        sts_card_int,
	// Card link pins
	input  wire logic        card_clk,
	input  wire logic        dat1_i,
	input  wire logic        dat2_i,
	output logic             dat2_o,
	output logic             dat2_oe,
	// Events
	output logic             card_int_det,
	output logic             wake_event,
	output logic             irq
);

	bgw_pkg::bgw_gap_s  gap_q;
	bgw_pkg::bgw_wake_s wake_q;
	bgw_pkg::bgw_mode_s mode_q;
	bgw_pkg::bgw_irq_t  irq_sts_q;
	bgw_pkg::bgw_irq_t  irq_en_q;
	bgw_pkg::bgw_irq_t  irq_set;
	bgw_pkg::bgw_irq_t  irq_clr;
	bgw_pkg::bgw_xfer_e xs_q;
	bgw_pkg::bgw_xfer_e xs_d;
	bgw_pkg::bgw_gap_s  wgap;

	logic [bgw_pkg::DEC_W-1:0] waddr_q;
	logic [bgw_pkg::DEC_W-1:0] raddr_q;
	logic                      wr_pend_q;
	logic                      rd_pend_q;
	logic [31:0]               hrdata_q;
	logic                      addr_ok;
	logic [2:0]                pin_s;
	logic                      clk_prev_q;
	logic                      clk_rise;
	logic                      int_line;
	logic                      int_allow;
	logic                      int_low_q;
	logic                      card_int_q;
	logic [2:0]                wake_src;
	logic [2:0]                wake_prev_q;
	logic                      wake_q_evt;
	logic                      dat_prev_q;
	logic                      wxa_prev_q;
	logic                      restart_rise;
	logic                      rw_usable;
	logic                      dat2_oe_q;
	logic                      clk_stop_q;
	logic                      sr_q;
	logic                      gap_wr;
	logic                      gap_evt;

	function automatic logic reg_hit(input logic [bgw_pkg::DEC_W-1:0] a,
			input logic [7:0] idx);
		reg_hit = (a == {idx, 2'b00});
	endfunction

	// AHB-Lite: writes take no wait; reads take one so read data see the last write
	assign addr_ok   = hsel & hready & htrans[1];
	assign hreadyout = ~rd_pend_q;
	assign hrdata    = hrdata_q;
	assign hresp     = 1'b0;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			waddr_q   <= '0;
			raddr_q   <= '0;
		end else begin
			wr_pend_q <= addr_ok & hwrite;
			rd_pend_q <= addr_ok & ~hwrite;
			if (addr_ok) begin
				waddr_q <= haddr[bgw_pkg::DEC_W-1:0];
				raddr_q <= haddr[bgw_pkg::DEC_W-1:0];
			end
		end
	end

	// Read data registered during the wait cycle; unmapped reads return zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (rd_pend_q) begin
			hrdata_q <= '0;
			if (reg_hit(raddr_q, bgw_pkg::IDX_GAP_CTRL))
				hrdata_q[bgw_pkg::GAP_W-1:0] <= gap_q; // RULE18
			if (reg_hit(raddr_q, bgw_pkg::IDX_WAKE_EN))
				hrdata_q[bgw_pkg::WAKE_W-1:0] <= wake_q; // RULE18
			if (reg_hit(raddr_q, bgw_pkg::IDX_MODE))
				hrdata_q[bgw_pkg::MODE_W-1:0] <= mode_q;
			if (reg_hit(raddr_q, bgw_pkg::IDX_IRQ_STS))
				hrdata_q[bgw_pkg::IRQ_W-1:0] <= irq_sts_q;
			if (reg_hit(raddr_q, bgw_pkg::IDX_IRQ_EN))
				hrdata_q[bgw_pkg::IRQ_W-1:0] <= irq_en_q;
			if (reg_hit(raddr_q, bgw_pkg::IDX_XFER_STS)) begin
				hrdata_q[bgw_pkg::XS_HALTED]   <= (xs_q == bgw_pkg::XS_HALT);
				hrdata_q[bgw_pkg::XS_RESUMING] <= (xs_q == bgw_pkg::XS_RESUME);
				hrdata_q[bgw_pkg::XS_SR_OK]    <= sr_q;
			end
		end
	end

	assign gap_wr = wr_pend_q & reg_hit(waddr_q, bgw_pkg::IDX_GAP_CTRL);
	assign wgap   = bgw_pkg::bgw_gap_s'(hwdata[bgw_pkg::GAP_W-1:0]);

	// Restart seen as rising activity of the transfer direction in use
	assign restart_rise = xfer_read ? (dat_line_active & ~dat_prev_q)
		: (write_xfer_active & ~wxa_prev_q);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dat_prev_q <= 1'b0;
			wxa_prev_q <= 1'b0;
		end else begin
			dat_prev_q <= dat_line_active;
			wxa_prev_q <= write_xfer_active;
		end
	end

	// Gap control; continue is write-one, cleared by hardware on restart
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			gap_q <= bgw_pkg::GAP_RST;
		end else begin
			if (gap_q.cont && restart_rise)
				gap_q.cont <= 1'b0; // RULE10
			if (gap_wr) begin
				gap_q.int_at_gap <= wgap.int_at_gap;
				gap_q.rw_en      <= wgap.rw_en;
				gap_q.stop       <= wgap.stop; // RULE17
				// Judged on the stop value this same write leaves behind
				if (wgap.cont && !wgap.stop)
					gap_q.cont <= 1'b1; // RULE8 RULE9
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_q <= bgw_pkg::WAKE_RST;
			mode_q <= bgw_pkg::MODE_RST;
			irq_en_q <= bgw_pkg::IRQ_RST;
		end else if (wr_pend_q) begin
			if (reg_hit(waddr_q, bgw_pkg::IDX_WAKE_EN))
				wake_q <= bgw_pkg::bgw_wake_s'(hwdata[bgw_pkg::WAKE_W-1:0]); // RULE18
			if (reg_hit(waddr_q, bgw_pkg::IDX_MODE))
				mode_q <= bgw_pkg::bgw_mode_s'(hwdata[bgw_pkg::MODE_W-1:0]);
			if (reg_hit(waddr_q, bgw_pkg::IDX_IRQ_EN))
				irq_en_q <= hwdata[bgw_pkg::IRQ_W-1:0];
		end
	end

	// Gap sequencer
	assign gap_evt = (xs_q == bgw_pkg::XS_RUN) & blk_gap_pulse & xfer_multi & gap_q.stop;

	always_comb begin
		xs_d = xs_q;
		case (xs_q)
			bgw_pkg::XS_RUN: begin
				if (gap_evt)
					xs_d = bgw_pkg::XS_HALT; // RULE17
			end
			bgw_pkg::XS_HALT: begin
				if (gap_q.cont && !gap_q.stop)
					xs_d = bgw_pkg::XS_RESUME; // RULE8 RULE11
			end
			bgw_pkg::XS_RESUME: begin
				if (restart_rise)
					xs_d = bgw_pkg::XS_RUN;
			end
			default: xs_d = bgw_pkg::XS_RUN;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			xs_q <= bgw_pkg::XS_RUN;
		else
			xs_q <= xs_d;
	end

	assign gap_hold = (xs_q == bgw_pkg::XS_HALT);

	// Read hold method; serial mode never uses read wait
	assign rw_usable = gap_q.rw_en & ~mode_q.uhs2; // RULE7

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clk_stop_q <= 1'b0;
			sr_q       <= 1'b0;
		end else begin
			clk_stop_q <= gap_hold & xfer_read & ~rw_usable; // RULE4
			sr_q       <= rw_usable; // RULE5
		end
	end

	assign card_clk_stop = clk_stop_q;
	assign sr_allowed    = sr_q;

	// Card pins cross into hclk
	bgw_sync #(
		.W(3)
	) u_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.async_i ({dat2_i, dat1_i, card_clk}),
		.sync_o  (pin_s)
	);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			clk_prev_q <= 1'b0;
		else
			clk_prev_q <= pin_s[0];
	end

	assign clk_rise = pin_s[0] & ~clk_prev_q;

	// Read wait drive moves on card clock edges, but drops at once when disallowed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			dat2_oe_q <= 1'b0;
		else if (clk_rise)
			dat2_oe_q <= gap_hold & xfer_read & rw_usable; // RULE4
		else
			dat2_oe_q <= dat2_oe_q & gap_hold & xfer_read & rw_usable; // RULE7
	end

	assign dat2_oe = dat2_oe_q;
	assign dat2_o  = 1'b0;

	// Card interrupt: low level on DAT[1], or on DAT[2] in serial mode
	assign int_line  = mode_q.uhs2 ? pin_s[2] : pin_s[1]; // RULE7
	assign int_allow = mode_q.uhs2 | ~(xfer_multi & mode_q.bus4 & mode_q.io_card)
		| (gap_q.int_at_gap & (gap_window | gap_hold)); // RULE1

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			int_low_q  <= 1'b0;
			card_int_q <= 1'b0;
		end else begin
			card_int_q <= clk_rise & ~int_line & int_allow & ~int_low_q; // RULE1
			if (clk_rise)
				int_low_q <= ~int_line & int_allow;
		end
	end

	assign card_int_det = card_int_q;

	// Wakeup on a rising enabled status, independent of card wake support
	assign wake_src = {sts_card_remove & wake_q.on_remove, // RULE12
		sts_card_insert & wake_q.on_insert, // RULE13
		sts_card_int & wake_q.on_cardint}; // RULE14

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_prev_q <= '0;
			wake_q_evt  <= 1'b0;
		end else begin
			wake_prev_q <= wake_src;
			wake_q_evt  <= |(wake_src & ~wake_prev_q);
		end
	end

	assign wake_event = wake_q_evt;

	// Sticky status; a set in the clearing cycle survives
	always_comb begin
		irq_set = '0;
		irq_set[bgw_pkg::IRQ_GAP]  = gap_evt;
		irq_set[bgw_pkg::IRQ_CARD] = card_int_q;
		irq_set[bgw_pkg::IRQ_WAKE] = wake_q_evt;
		irq_clr = '0;
		if (wr_pend_q && reg_hit(waddr_q, bgw_pkg::IDX_IRQ_CLR))
			irq_clr = hwdata[bgw_pkg::IRQ_W-1:0];
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			irq_sts_q <= bgw_pkg::IRQ_RST;
		else
			irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
	end

	assign irq = |(irq_sts_q & irq_en_q);

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_gap_stop;
		gap_evt;
	endsequence

	sequence s_cont_req;
		gap_hold && gap_q.cont && !gap_q.stop;
	endsequence

	property p_halt_at_gap; // RULE17
		s_gap_stop |=> gap_hold && irq_sts_q[bgw_pkg::IRQ_GAP];
	endproperty
	a_halt_at_gap: assert property (p_halt_at_gap) else $error("no halt at gap"); // RULE17

	property p_halt_holds; // RULE17
		gap_hold && gap_q.stop |=> gap_hold;
	endproperty
	a_halt_holds: assert property (p_halt_holds) else $error("halt left early"); // RULE17

	property p_resume; // RULE8
		s_cont_req |=> !gap_hold && xs_q == bgw_pkg::XS_RESUME;
	endproperty
	a_resume: assert property (p_resume) else $error("continue ignored"); // RULE8

	property p_cont_ignored; // RULE9
		gap_wr && wgap.stop && !gap_q.cont |=> !gap_q.cont;
	endproperty
	a_cont_ignored: assert property (p_cont_ignored) else $error("continue taken"); // RULE9

	property p_cont_autoclr; // RULE10
		gap_q.cont && xfer_read && $rose(dat_line_active) && !gap_wr |=> !gap_q.cont;
	endproperty
	a_cont_autoclr: assert property (p_cont_autoclr) else $error("continue stuck"); // RULE10

	property p_rw_drive; // RULE4
		// Drive enable is registered, so it answers to last cycle's conditions
		dat2_oe |-> $past(gap_q.rw_en && !mode_q.uhs2 && gap_hold);
	endproperty
	a_rw_drive: assert property (p_rw_drive) else $error("bad read wait drive"); // RULE4

	property p_clk_stop; // RULE7
		gap_hold && xfer_read && mode_q.uhs2 |=> card_clk_stop && !dat2_oe;
	endproperty
	a_clk_stop: assert property (p_clk_stop) else $error("serial mode hold wrong"); // RULE7

	property p_no_sr; // RULE5
		!gap_q.rw_en ##1 !gap_q.rw_en |-> !sr_allowed;
	endproperty
	a_no_sr: assert property (p_no_sr) else $error("suspend allowed"); // RULE5

	property p_int_gated; // RULE1
		card_int_det |-> $past(int_allow);
	endproperty
	a_int_gated: assert property (p_int_gated) else $error("interrupt mid transfer"); // RULE1

	property p_wake_rem; // RULE12
		sts_card_remove && wake_q.on_remove && !$past(sts_card_remove) |=> wake_event;
	endproperty
	a_wake_rem: assert property (p_wake_rem) else $error("no removal wake"); // RULE12

	property p_wake_ins; // RULE13
		sts_card_insert && wake_q.on_insert && !$past(sts_card_insert) |=> wake_event;
	endproperty
	a_wake_ins: assert property (p_wake_ins) else $error("no insertion wake"); // RULE13

	property p_wake_ci; // RULE14
		sts_card_int && wake_q.on_cardint && !$past(sts_card_int) |=> wake_event;
	endproperty
	a_wake_ci: assert property (p_wake_ci) else $error("no card int wake"); // RULE14

	property p_rsvd_zero; // RULE18
		rd_pend_q && reg_hit(raddr_q, bgw_pkg::IDX_GAP_CTRL) |=> hrdata[7:4] == 4'h0;
	endproperty
	a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set"); // RULE18

endmodule // bgw_ctrl

/* hdl/bgw_pkg.sv */
/*
 Package for the block gap and wakeup control block: register indices,
 field layouts, reset values, interrupt bit positions and transfer states.
 Assumes a 32-bit AHB-Lite register bus where each register index occupies
 one aligned word at byte address four times the index.
*/
package bgw_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_GAP_CTRL = 8'h2A;
	localparam logic [7:0] IDX_WAKE_EN  = 8'h2B;
	localparam logic [7:0] IDX_MODE     = 8'h38;
	localparam logic [7:0] IDX_IRQ_STS  = 8'h39;
	localparam logic [7:0] IDX_IRQ_CLR  = 8'h3A;
	localparam logic [7:0] IDX_IRQ_EN   = 8'h3B;
	localparam logic [7:0] IDX_XFER_STS = 8'h3C;

	localparam int unsigned DEC_W   = 10;
	localparam int unsigned GAP_W   = 4;
	localparam int unsigned WAKE_W  = 3;
	localparam int unsigned MODE_W  = 3;
	localparam int unsigned IRQ_W   = 3;
	localparam int unsigned XSTS_W  = 3;

	// Transfer gap control; reserved bits 7..4 are not stored
	typedef struct packed {
		logic int_at_gap;
		logic rw_en;
		logic cont;
		logic stop;
	} bgw_gap_s;

	typedef struct packed {
		logic on_remove;
		logic on_insert;
		logic on_cardint;
	} bgw_wake_s;

	// Link mode: second-generation serial bus, I/O card, 4-bit data width
	typedef struct packed {
		logic uhs2;
		logic io_card;
		logic bus4;
	} bgw_mode_s;

	typedef logic [IRQ_W-1:0] bgw_irq_t;

	localparam bgw_gap_s  GAP_RST  = 4'h0;
	localparam bgw_wake_s WAKE_RST = 3'h0;
	localparam bgw_mode_s MODE_RST = 3'h0;
	localparam bgw_irq_t  IRQ_RST  = 3'h0;

	// Interrupt status bit positions
	localparam int unsigned IRQ_GAP  = 0;
	localparam int unsigned IRQ_CARD = 1;
	localparam int unsigned IRQ_WAKE = 2;

	// Transfer status bit positions
	localparam int unsigned XS_HALTED = 0;
	localparam int unsigned XS_RESUMING = 1;
	localparam int unsigned XS_SR_OK = 2;

	typedef enum logic [1:0] {
		XS_RUN    = 2'b00,
		XS_HALT   = 2'b01,
		XS_RESUME = 2'b10
	} bgw_xfer_e;

	localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'h2;

endpackage

/* hdl/bgw_sync.sv */
/*
 Two-flop synchroniser, one lane per bit.
 Assumes inputs are asynchronous to hclk; only the second flop is visible.
*/
`timescale 1ns/10ps
module bgw_sync #(
	parameter int unsigned W = 3
) (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// Asynchronous in, synchronous out
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	genvar gi;
	generate
		for (gi = 0; gi < W; gi++) begin : g_lane
			logic meta_q;
			logic sync_q;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					meta_q <= 1'b0;
					sync_q <= 1'b0;
				end else begin
					meta_q <= async_i[gi];
					sync_q <= meta_q;
				end
			end
			assign sync_o[gi] = sync_q;
		end
	endgenerate

endmodule // bgw_sync

/* dv/bgw_card_model.sv */
/*
 Card-side model: the card's link clock and its DAT[1] and DAT[2] lines.
 Assumes the bench opens frames with run and requests interrupts with irq_req.
*/
`timescale 1ns/10ps
module bgw_card_model (
	// Frame and interrupt control
	input  wire logic run,
	input  wire logic irq_req,
	input  wire logic int_dat2,
	// Card pins
	output logic      card_clk,
	output logic      dat1,
	output logic      dat2,
	input  wire logic dat2_drv,
	input  wire logic dat2_en
);
	// Odd start offset keeps the link clock unrelated to hclk
	initial begin
		card_clk = 1'b0;
		#13;
		forever #200 card_clk = run ? ~card_clk : 1'b0;
	end

	// Released lines sit at the pull-up level
	// Serial mode moves the card interrupt onto DAT[2]
	assign dat1 = (irq_req & ~int_dat2) ? 1'b0 : 1'b1;
	assign dat2 = dat2_en ? dat2_drv : ~(irq_req & int_dat2);
endmodule // bgw_card_model

/* dv/test_block_gap_wakeup_ctrl.sv */
/*
 Self-checking bench for the gap and wakeup control block.
 Assumes bgw_pkg, bgw_sync, bgw_ctrl and the card model are compiled first.
*/
`timescale 1ns/10ps
module test_block_gap_wakeup_ctrl;
	localparam logic [7:0] G  = bgw_pkg::IDX_GAP_CTRL;
	localparam logic [7:0] W  = bgw_pkg::IDX_WAKE_EN;
	localparam logic [7:0] MD = bgw_pkg::IDX_MODE;
	localparam logic [7:0] ST = bgw_pkg::IDX_IRQ_STS;
	localparam logic [7:0] CL = bgw_pkg::IDX_IRQ_CLR;
	localparam logic [7:0] EN = bgw_pkg::IDX_IRQ_EN;
	localparam logic [7:0] XS = bgw_pkg::IDX_XFER_STS;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, q;
	logic        hreadyout, hresp, gap_hold, card_clk_stop, sr_allowed;
	logic        xfer_multi = 1'b0;
	logic        xfer_read = 1'b0;
	logic        blk_gap_pulse = 1'b0;
	logic        gap_window = 1'b0;
	logic        dat_line_active = 1'b0;
	logic        write_xfer_active = 1'b0;
	logic        run = 1'b0;
	logic        irq_req = 1'b0;
	logic        int_dat2 = 1'b0;
	logic [2:0]  st = 3'h0;
	logic        card_clk, dat1_i, dat2_i, dat2_o, dat2_oe, card_int_det, wake_event, irq;
	int          err_total = 0;
	int          num_checks = 0;
	int          n_ci = 0;
	int          n_wk = 0;
	int          m_gap = 0;
	int          m_wake = 0;
	int          m_sts = 0;
	int          mask, src, e;
	integer      seed = 32'hE3189D44;
	logic [7:0]  rst_l [7] = '{G, W, MD, ST, EN, XS, 8'h10};

	bgw_ctrl u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .xfer_multi(xfer_multi),
		.xfer_read(xfer_read), .blk_gap_pulse(blk_gap_pulse), .gap_window(gap_window),
		.dat_line_active(dat_line_active), .write_xfer_active(write_xfer_active),
		.gap_hold(gap_hold), .card_clk_stop(card_clk_stop), .sr_allowed(sr_allowed),
		.sts_card_insert(st[1]), .sts_card_remove(st[2]), .sts_card_int(st[0]),
		.card_clk(card_clk), .dat1_i(dat1_i), .dat2_i(dat2_i), .dat2_o(dat2_o),
		.dat2_oe(dat2_oe), .card_int_det(card_int_det), .wake_event(wake_event), .irq(irq)
	);

	bgw_card_model u_card (
		.run(run), .irq_req(irq_req), .int_dat2(int_dat2), .card_clk(card_clk), .dat1(dat1_i),
		.dat2(dat2_i), .dat2_drv(dat2_o), .dat2_en(dat2_oe)
	);

	always #25 hclk = ~hclk;

	always @(posedge hclk) begin
		if (card_int_det === 1'b1) n_ci++;
		if (wake_event === 1'b1) n_wk++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Entered just after a rising edge; returns just after the data phase edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {22'h0, a, 2'h0};
		htrans <= bgw_pkg::HTRANS_NONSEQ_BIT;
		hwrite <= w;
		@(posedge hclk iff hreadyout === 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk iff hreadyout === 1'b1);
		q = hrdata;
	endtask

	// Write plus the reference model's view of it
	task automatic wr(input logic [7:0] a, input int d);
		ahb(1'b1, a, d);
		if (a == G) m_gap = (d & 32'hD) | (m_gap & 2) | (((d & 3) == 2) ? 2 : 0);
		if (a == W) m_wake = d & 7;
		if (a == CL) m_sts = m_sts & ~d;
	endtask

	task automatic rc(input logic [7:0] a, input int exp);
		ahb(1'b0, a, 32'h0);
		chk(q, exp);
	endtask

	task automatic halt(input logic rd, input int ctl);
		wr(G, ctl);
		xfer_read <= rd;
		xfer_multi <= 1'b1;
		blk_gap_pulse <= 1'b1;
		@(posedge hclk);
		blk_gap_pulse <= 1'b0;
		repeat (3) @(posedge hclk);
		m_sts = m_sts | 1;
		chk(gap_hold, 1'b1);
	endtask

	task automatic resume(input logic rd);
		wr(G, (m_gap & 32'hC) | 32'h2);
		repeat (3) @(posedge hclk);
		chk(gap_hold, 1'b0);
		rc(XS, 2 | (m_gap & 4));
		rc(G, m_gap);
		if (rd) dat_line_active <= 1'b1;
		else write_xfer_active <= 1'b1;
		repeat (3) @(posedge hclk);
		m_gap = m_gap & 32'hD;
		rc(G, m_gap);
		dat_line_active <= 1'b0;
		write_xfer_active <= 1'b0;
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		foreach (rst_l[i]) rc(rst_l[i], 32'h0);
		wr(G, 32'hFFFFFFFF);
		rc(G, m_gap);
		wr(W, 32'hFFFFFFFF);
		rc(W, m_wake);
		wr(8'h10, 32'hFFFFFFFF);
		rc(8'h10, 32'h0);
		wr(G, 32'h0);
		$display("test registers done");
		wr(EN, 32'h1);
		for (int d = 1; d >= 0; d--) begin
			halt(d[0], 32'h1);
			chk(irq, 1'b1);
			chk(card_clk_stop, d[0]);
			chk(sr_allowed, 1'b0);
			rc(XS, 32'h1);
			wr(G, 32'h3);
			rc(G, m_gap);
			chk(gap_hold, 1'b1);
			resume(d[0]);
			wr(EN, 32'h0);
			@(posedge hclk);
			chk(irq, 1'b0);
			rc(ST, m_sts);
			wr(EN, 32'h1);
			wr(CL, 32'h1);
			@(posedge hclk);
			chk(irq, 1'b0);
			rc(ST, m_sts);
		end
		$display("test gap done");
		run <= 1'b1;
		halt(1'b1, 32'h5);
		repeat (20) @(posedge hclk);
		chk(dat2_oe, 1'b1);
		chk(dat2_o, 1'b0);
		chk(sr_allowed, 1'b1);
		chk(card_clk_stop, 1'b0);
		wr(MD, 32'h4);
		repeat (20) @(posedge hclk);
		chk(dat2_oe, 1'b0);
		chk(sr_allowed, 1'b0);
		wr(MD, 32'h0);
		resume(1'b1);
		wr(CL, 32'h7);
		$display("test read wait done");
		wr(MD, 32'h3);
		wr(G, 32'h0);
		xfer_multi <= 1'b1;
		n_ci = 0;
		irq_req <= 1'b1;
		repeat (40) @(posedge hclk);
		chk(n_ci, 0);
		irq_req <= 1'b0;
		repeat (40) @(posedge hclk);
		wr(G, 32'h8);
		gap_window <= 1'b1;
		irq_req <= 1'b1;
		repeat (40) @(posedge hclk);
		m_sts = m_sts | 2;
		chk(n_ci, 1);
		rc(ST, m_sts);
		irq_req <= 1'b0;
		repeat (20) @(posedge hclk);
		wr(MD, 32'h7);
		int_dat2 <= 1'b1;
		irq_req <= 1'b1;
		n_ci = 0;
		repeat (40) @(posedge hclk);
		chk(n_ci, 1);
		irq_req <= 1'b0;
		int_dat2 <= 1'b0;
		gap_window <= 1'b0;
		xfer_multi <= 1'b0;
		run <= 1'b0;
		wr(CL, 32'h7);
		$display("test card interrupt done");
		for (int k = 0; k < 12; k++) begin
			mask = (k < 3) ? (1 << k) : ($random(seed) & 7);
			src = (k < 3) ? (1 << k) : ($random(seed) & 7);
			wr(W, mask);
			rc(W, m_wake);
			n_wk = 0;
			st <= src[2:0];
			repeat (4) @(posedge hclk);
			e = ((mask & src) != 0);
			chk(n_wk, e);
			m_sts = m_sts | (e << 2);
			rc(ST, m_sts);
			st <= 3'h0;
			repeat (2) @(posedge hclk);
		end
		$display("test wake done");
		tally_and_finish();
	end

	// Whole run needs well under 300 us
	initial begin
		#1000000;
		err_total++;
		tally_and_finish();
	end
endmodule // test_block_gap_wakeup_ctrl
